// ==== hw/acms_top.sv ====
// Converter clock, mode and sample configuration block with AXI4-Lite register slave
//
// The address map and the AXI4-Lite register port were decided locally.
`timescale 1ns/100ps
module acms_top
	import acms_pkg::*;
#(
	parameter int ASYNC_DIV            = 4,
	parameter int ASYNC_STARTUP_CYCLES = ACMS_ASYNC_STARTUP_CYC
)(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst,
	// AXI4-Lite write address
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Alternate clock pin
	input  wire logic        alternate_clock,
	// Converter side
	input  wire logic        differential_select,
	input  wire logic        conv_active,
	input  wire logic        conv_start_req,
	input  wire logic [15:0] raw_result,
	input  wire logic        raw_result_valid,
	output logic             conv_start,
	output logic             conversion_clock,
	output logic             low_power_select,
	output logic [4:0]       resolution_bits,
	output logic             twos_complement,
	output logic [5:0]       sample_cycles,
	output logic [5:0]       conversion_cycles,
	output logic [15:0]      result_data,
	output logic             result_valid,
	// Exported asynchronous clock
	output logic             internal_async_clock,
	output logic             async_clock_ready
);

	// ----------------------------------------------------------------
	// Resolution decode
	// ----------------------------------------------------------------
	function automatic logic [4:0] acms_res(input logic [1:0] mode, input logic diff);
		logic [4:0] bits;
		bits = 5'h10;
		case (mode)
			2'h0: bits = diff ? 5'h09 : 5'h08;
			2'h1: bits = diff ? 5'h0D : 5'h0C;
			2'h2: bits = diff ? 5'h0B : 5'h0A;
			default: bits = 5'h10;
		endcase
		return bits;
	endfunction : acms_res

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic [7:0]  cfg_one_reg;
	logic [7:0]  cfg_two_reg;
	logic [7:0]  awaddr_reg;
	logic        aw_held_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  wstrb_reg;
	logic        w_held_reg;

	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held_reg <= 1'b1;
				awaddr_reg  <= s_axi_awaddr;
			end
			else if (aw_held_reg && w_held_reg)
				aw_held_reg <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held_reg <= 1'b1;
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
			end
			else if (aw_held_reg && w_held_reg)
				w_held_reg <= 1'b0;
		end
	end

	// Write commit and response
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			cfg_one_reg  <= ACMS_CFG_ONE_RST;
			cfg_two_reg  <= ACMS_CFG_TWO_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ACMS_RESP_OKAY;
		end
		else if (aw_held_reg && w_held_reg)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= ACMS_RESP_OKAY;
			if (awaddr_reg[7:2] == ACMS_OFF_CFG_ONE[7:2])
			begin
				if (wstrb_reg[0])
					cfg_one_reg <= wdata_reg[7:0];
			end
			else if (awaddr_reg[7:2] == ACMS_OFF_CFG_TWO[7:2])
			begin
				if (wstrb_reg[0])
					cfg_two_reg <= wdata_reg[7:0] & ACMS_CFG_TWO_MASK;
			end
			else
				s_axi_bresp <= ACMS_RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// Read path
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= ACMS_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= ACMS_RESP_OKAY;
			if (s_axi_araddr[7:2] == ACMS_OFF_CFG_ONE[7:2])
				s_axi_rdata <= {24'h00_0000, cfg_one_reg};
			else if (s_axi_araddr[7:2] == ACMS_OFF_CFG_TWO[7:2])
				s_axi_rdata <= {24'h00_0000, cfg_two_reg & ACMS_CFG_TWO_MASK};
			else
			begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= ACMS_RESP_SLVERR;
			end
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ----------------------------------------------------------------
	// Field extraction
	// ----------------------------------------------------------------
	logic [1:0] input_clock_select;
	logic [1:0] mode_field;
	logic       long_sample_select;
	logic [1:0] clock_divider_field;
	logic [1:0] long_sample_length;
	logic       high_speed_sequence;
	logic       async_clock_enable;

	assign input_clock_select  = cfg_one_reg[ACMS_CLKSEL_LSB +: 2];
	assign mode_field          = cfg_one_reg[ACMS_MODE_LSB +: 2];
	assign long_sample_select  = cfg_one_reg[ACMS_LSMP_BIT];
	assign clock_divider_field = cfg_one_reg[ACMS_DIV_LSB +: 2];
	assign long_sample_length  = cfg_two_reg[ACMS_LSTS_LSB +: 2];
	assign high_speed_sequence = cfg_two_reg[ACMS_HSC_BIT];
	assign async_clock_enable  = cfg_two_reg[ACMS_ACKEN_BIT];

	// ----------------------------------------------------------------
	// Alternate clock pin synchroniser
	// ----------------------------------------------------------------
	logic [2:0] alt_sync_reg;
	logic       alt_level_reg;
	logic       alt_rise;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			alt_sync_reg  <= 3'h0;
			alt_level_reg <= 1'b0;
		end
		else
		begin
			alt_sync_reg <= {alt_sync_reg[1:0], alternate_clock};
			if (alt_sync_reg[1] == alt_sync_reg[2])
				alt_level_reg <= alt_sync_reg[2];
		end
	end
	assign alt_rise = (alt_sync_reg[1] == alt_sync_reg[2]) && alt_sync_reg[2] && !alt_level_reg;

	// ----------------------------------------------------------------
	// Asynchronous clock model
	// ----------------------------------------------------------------
	logic        async_run;
	logic [15:0] async_cnt_reg;
	logic [15:0] startup_cnt_reg;
	logic        async_tick;

	assign async_run = async_clock_enable ||
		(conv_active && (input_clock_select == ACMS_SRC_ASYNC));

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			async_cnt_reg        <= 16'h0000;
			startup_cnt_reg      <= 16'h0000;
			async_clock_ready    <= 1'b0;
			internal_async_clock <= 1'b0;
		end
		else if (!async_run)
		begin
			// Oscillator stops; next start pays the start-up delay again
			async_cnt_reg        <= 16'h0000;
			startup_cnt_reg      <= 16'h0000;
			async_clock_ready    <= 1'b0;
			internal_async_clock <= 1'b0;
		end
		else if (!async_clock_ready)
		begin
			startup_cnt_reg <= startup_cnt_reg + 16'h0001;
			if (startup_cnt_reg == 16'(ASYNC_STARTUP_CYCLES - 1))
				async_clock_ready <= 1'b1;
		end
		else if (async_cnt_reg == 16'(ASYNC_DIV - 1))
		begin
			async_cnt_reg        <= 16'h0000;
			internal_async_clock <= !internal_async_clock;
		end
		else
			async_cnt_reg <= async_cnt_reg + 16'h0001;
	end
	assign async_tick = async_clock_ready && (async_cnt_reg == 16'(ASYNC_DIV - 1))
		&& !internal_async_clock;

	// ----------------------------------------------------------------
	// Conversion clock source and divider
	// ----------------------------------------------------------------
	logic       bus_half_reg;
	logic       src_tick;
	logic [2:0] div_cnt_reg;
	logic [2:0] div_last;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			bus_half_reg <= 1'b0;
		else
			bus_half_reg <= !bus_half_reg;
	end

	always_comb
	begin
		src_tick = 1'b0;
		case (input_clock_select)
			ACMS_SRC_BUS:      src_tick = 1'b1;
			ACMS_SRC_BUS_HALF: src_tick = bus_half_reg;
			ACMS_SRC_ALT:      src_tick = alt_rise;
			default:           src_tick = async_tick;
		endcase
	end

	assign div_last = 3'((4'h1 << clock_divider_field) - 4'h1);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			div_cnt_reg      <= 3'h0;
			conversion_clock <= 1'b0;
		end
		else
		begin
			conversion_clock <= 1'b0;
			if (src_tick)
			begin
				if (div_cnt_reg >= div_last)
				begin
					div_cnt_reg      <= 3'h0;
					conversion_clock <= 1'b1;
				end
				else
					div_cnt_reg <= div_cnt_reg + 3'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Conversion start gating
	// ----------------------------------------------------------------
	logic start_pending_reg;
	logic start_ok;

	// No wait once async clock is up
	assign start_ok = (input_clock_select != ACMS_SRC_ASYNC) || async_clock_ready;

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			start_pending_reg <= 1'b0;
			conv_start        <= 1'b0;
		end
		else
		begin
			conv_start <= 1'b0;
			if ((start_pending_reg || conv_start_req) && start_ok)
			begin
				start_pending_reg <= 1'b0;
				conv_start        <= 1'b1;
			end
			else if (conv_start_req)
				start_pending_reg <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Mode, sample and cycle configuration
	// ----------------------------------------------------------------
	logic [5:0] sample_next;
	logic [5:0] conv_next;

	always_comb
	begin
		// Length field only in long mode
		sample_next = ACMS_SAMPLE_SHORT;
		if (long_sample_select)
		begin
			case (long_sample_length)
				2'h0:    sample_next = ACMS_SAMPLE_L0;
				2'h1:    sample_next = ACMS_SAMPLE_L1;
				2'h2:    sample_next = ACMS_SAMPLE_L2;
				default: sample_next = ACMS_SAMPLE_L3;
			endcase
		end
		conv_next = sample_next + {1'b0, acms_res(mode_field, differential_select)};
		if (high_speed_sequence)
			conv_next = conv_next + ACMS_HSC_EXTRA;
		if (differential_select)
			conv_next = conv_next + ACMS_DIFF_EXTRA;
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			sample_cycles     <= ACMS_SAMPLE_SHORT;
			conversion_cycles <= ACMS_SAMPLE_SHORT;
			resolution_bits   <= 5'h08;
			twos_complement   <= 1'b0;
			low_power_select  <= 1'b0;
		end
		else
		begin
			sample_cycles     <= sample_next;
			conversion_cycles <= conv_next;
			resolution_bits   <= acms_res(mode_field, differential_select);
			twos_complement   <= differential_select;
			low_power_select  <= cfg_one_reg[ACMS_LPC_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Result formatting
	// ----------------------------------------------------------------
	logic [15:0] fmt;
	logic [4:0]  res_now;

	assign res_now = acms_res(mode_field, differential_select);

	// Sign extend differential, zero fill single-ended
	always_comb
	begin
		fmt = 16'h0000;
		for (int i = 0; i < 16; i++)
		begin
			if (5'(i) < res_now)
				fmt[i] = raw_result[i];
			else
				fmt[i] = differential_select && raw_result[4'(res_now - 5'h01)];
		end
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			result_data  <= 16'h0000;
			result_valid <= 1'b0;
		end
		else
		begin
			result_valid <= raw_result_valid;
			if (raw_result_valid)
				result_data <= fmt;
		end
	end

endmodule : acms_top

// ==== shared/acms_pkg.sv ====
// Package: register map, field layout, reset values and timing for the converter clock config
package acms_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] ACMS_OFF_CFG_ONE = 8'h00;
	localparam logic [7:0] ACMS_OFF_CFG_TWO = 8'h04;

	// ----------------------------------------------------------------
	// Field positions, first configuration register
	// ----------------------------------------------------------------
	localparam int ACMS_CLKSEL_LSB = 0;
	localparam int ACMS_MODE_LSB   = 2;
	localparam int ACMS_LSMP_BIT   = 4;
	localparam int ACMS_DIV_LSB    = 5;
	localparam int ACMS_LPC_BIT    = 7;

	// ----------------------------------------------------------------
	// Field positions, second configuration register
	// ----------------------------------------------------------------
	localparam int ACMS_LSTS_LSB   = 0;
	localparam int ACMS_HSC_BIT    = 2;
	localparam int ACMS_ACKEN_BIT  = 3;
	localparam logic [7:0] ACMS_CFG_TWO_MASK = 8'h0F;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] ACMS_CFG_ONE_RST = 8'h00;
	localparam logic [7:0] ACMS_CFG_TWO_RST = 8'h00;

	// ----------------------------------------------------------------
	// Clock sources and responses
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {ACMS_SRC_BUS, ACMS_SRC_BUS_HALF, ACMS_SRC_ALT, ACMS_SRC_ASYNC}
		acms_src_t;
	localparam logic [1:0] ACMS_RESP_OKAY   = 2'h0;
	localparam logic [1:0] ACMS_RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Cycle counts, in conversion-clock cycles
	// ----------------------------------------------------------------
	localparam logic [5:0] ACMS_SAMPLE_SHORT = 6'h04;
	localparam logic [5:0] ACMS_SAMPLE_L0    = 6'h18;
	localparam logic [5:0] ACMS_SAMPLE_L1    = 6'h10;
	localparam logic [5:0] ACMS_SAMPLE_L2    = 6'h0A;
	localparam logic [5:0] ACMS_SAMPLE_L3    = 6'h06;
	localparam logic [5:0] ACMS_HSC_EXTRA    = 6'h04;
	localparam logic [5:0] ACMS_DIFF_EXTRA   = 6'h02;

	// ----------------------------------------------------------------
	// Asynchronous clock model timing
	// ----------------------------------------------------------------
	localparam int ACMS_CLK_SYS_MHZ      = 100;
	localparam int ACMS_ASYNC_STARTUP_NS = 5000;
	localparam int ACMS_ASYNC_STARTUP_CYC = (ACMS_ASYNC_STARTUP_NS * ACMS_CLK_SYS_MHZ + 999) / 1000;

endpackage : acms_pkg

// ==== testbench/acms_monitor.sv ====
// Checker: port assertions for the converter configuration block
`timescale 1ns/100ps
module acms_monitor
	import acms_pkg::*;
(
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        rst,
	// Register bus
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Converter side
	input wire logic        conv_start_req,
	input wire logic        raw_result_valid,
	input wire logic        conv_start,
	input wire logic [4:0]  resolution_bits,
	input wire logic        twos_complement,
	input wire logic [5:0]  sample_cycles,
	input wire logic [5:0]  conversion_cycles,
	input wire logic [15:0] result_data,
	input wire logic        result_valid,
	input wire logic        internal_async_clock,
	input wire logic        async_clock_ready
);
	// ------
	// Helpers
	// ------
	// What remains once sample, resolution and differential cycles are removed
	logic [5:0] extra;
	assign extra = conversion_cycles - sample_cycles - {1'b0, resolution_bits}
		- (twos_complement ? 6'h02 : 6'h00);

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// ------
	// Assertions
	// ------
	AST_RES_DIFF:
		assert property (twos_complement |-> resolution_bits inside {5'h09, 5'h0B, 5'h0D, 5'h10})
		else $error("differential resolution wrong");
	AST_RES_SE:
		assert property (!twos_complement |-> resolution_bits inside {5'h08, 5'h0A, 5'h0C, 5'h10})
		else $error("single-ended resolution wrong");
	AST_SAMPLE:
		assert property (sample_cycles inside {6'h04, 6'h18, 6'h10, 6'h0A, 6'h06})
		else $error("sample length not allowed");
	// Outputs still hold reset values at the first edge after release
	AST_CONV:
		assert property (!$past(rst) |-> extra inside {6'h00, 6'h04})
		else $error("conversion cycle total wrong");
	AST_START:
		assert property (conv_start_req && async_clock_ready |=> conv_start)
		else $error("start not granted with clock running");
	AST_RESULT:
		assert property (result_valid == $past(raw_result_valid))
		else $error("result strobe not one cycle after raw");
	AST_RESULT_SE:
		assert property (result_valid && !twos_complement && resolution_bits != 5'h10
			|-> (result_data >> resolution_bits) == 16'h0000)
		else $error("unsigned result has upper bits set");
	AST_ASYNC:
		assert property ($changed(internal_async_clock) |-> $past(async_clock_ready))
		else $error("async clock moved before start-up");
	AST_BHOLD:
		assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_RHOLD:
		assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped early");
	AST_BLOCK:
		assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
endmodule : acms_monitor

bind acms_top acms_monitor u_monitor (
	.clk_sys, .rst, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
	.conv_start_req, .raw_result_valid, .conv_start, .resolution_bits, .twos_complement,
	.sample_cycles, .conversion_cycles, .result_data, .result_valid,
	.internal_async_clock, .async_clock_ready
);

// ==== testbench/tb.sv ====
// Testbench: register access, configuration decode and async clock
`timescale 1ns/100ps
module tb
	import acms_pkg::*;
;
	logic        clk_sys, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic        s_axi_rvalid, conv_start, conversion_clock, low_power_select;
	logic        twos_complement, result_valid, internal_async_clock, async_clock_ready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [4:0]  resolution_bits;
	logic [5:0]  sample_cycles, conversion_cycles;
	logic [15:0] result_data;
	logic [31:0] s_axi_rdata;
	logic        rst = 1'b1, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, alternate_clock = 1'b0;
	logic        differential_select = 1'b0, conv_active = 1'b0, conv_start_req = 1'b0;
	logic        raw_result_valid = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [3:0]  s_axi_wstrb = 4'h0;
	logic [15:0] raw_result = 16'h0000;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	int          err_count = 0, comparisons = 0;

	acms_top #(.ASYNC_DIV(4), .ASYNC_STARTUP_CYCLES(4)) dut (
		.clk_sys, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .alternate_clock, .differential_select, .conv_active,
		.conv_start_req, .raw_result, .raw_result_valid, .conv_start, .conversion_clock,
		.low_power_select, .resolution_bits, .twos_complement, .sample_cycles,
		.conversion_cycles, .result_data, .result_valid, .internal_async_clock,
		.async_clock_ready
	);

	// ------
	// Clocks and watchdog
	// ------
	initial
	begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	// Alternate clock unrelated to the system clock
	initial forever #37.5 alternate_clock = ~alternate_clock;
	initial
	begin
		#200000;
		err_count++;
		end_sim();
	end

	// ------
	// Tasks and expectations
	// ------
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			err_count++;
			$display("FAIL %s expected %h seen %h", n, e, s);
		end
	endtask : chk

	task automatic end_sim();
		if (err_count == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	// Response ready is sometimes raised only after the response shows
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
		output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= st;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'($urandom_range(0, 1));
		forever
		begin
			@(posedge clk_sys);
			if (s_axi_awvalid && s_axi_awready === 1'b1)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready === 1'b1)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bready && s_axi_bvalid === 1'b1)
			begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				break;
			end
			s_axi_bready <= (s_axi_bvalid === 1'b1) || s_axi_bready;
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'($urandom_range(0, 1));
		forever
		begin
			@(posedge clk_sys);
			if (s_axi_arvalid && s_axi_arready === 1'b1)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rready && s_axi_rvalid === 1'b1)
			begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				break;
			end
			s_axi_rready <= (s_axi_rvalid === 1'b1) || s_axi_rready;
		end
	endtask : axi_rd

	// Gap between two ticks, after two ticks let the new setting settle
	task automatic gap(output int g);
		repeat (2)
			do @(posedge clk_sys); while (conversion_clock !== 1'b1);
		g = 0;
		do
		begin
			@(posedge clk_sys);
			g++;
		end while (conversion_clock !== 1'b1);
	endtask : gap

	// Request one cycle, result of the grant checked right after
	task automatic req(input string n, input logic e);
		@(posedge clk_sys);
		conv_start_req <= 1'b1;
		@(posedge clk_sys);
		conv_start_req <= 1'b0;
		#1;
		chk(n, conv_start, e);
	endtask : req

	function automatic logic [4:0] exp_res(logic [1:0] m, logic df);
		return (m == 2'h3) ? 5'h10 : 5'h08 + {2'h0, m[0], m[1], 1'b0} + 5'(df);
	endfunction : exp_res

	function automatic logic [5:0] exp_smp(logic lng, logic [1:0] t);
		logic [5:0] tbl [4] = '{6'h18, 6'h10, 6'h0A, 6'h06};
		return lng ? tbl[t] : 6'h04;
	endfunction : exp_smp

	function automatic logic [15:0] exp_fmt(logic [15:0] v, logic [4:0] w, logic df);
		for (int b = 0; b < 16; b++)
			if (b >= w)
				v[b] = df ? v[w - 1] : 1'b0;
		return v;
	endfunction : exp_fmt

	// ------
	// Main sequence
	// ------
	initial
	begin
		logic [31:0] d;
		logic [1:0]  r;
		logic [7:0]  c1, c2;
		logic        dif;
		logic [15:0] raw;
		int          g, n;
		void'($urandom(32'h714C));
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		axi_rd(ACMS_OFF_CFG_ONE, d, r);
		chk("cfg_one reset", d, 32'(ACMS_CFG_ONE_RST));
		// Modes, differential and lengths: corners first, then random
		for (int i = 0; i < 24; i++)
		begin
			c1 = 8'($urandom);
			c2 = 8'($urandom);
			dif = (i < 16) ? i[2] : 1'($urandom);
			if (i < 16)
			begin
				c1[4:2] = {1'b1, i[1:0]};
				c2[1:0] = i[3:2];
			end
			axi_wr(ACMS_OFF_CFG_ONE, {24'h0, c1}, 4'hF, r);
			differential_select <= dif;
			axi_wr(ACMS_OFF_CFG_TWO, {24'h0, c2}, 4'hF, r);
			chk("write resp", r, ACMS_RESP_OKAY);
			axi_rd(ACMS_OFF_CFG_ONE, d, r);
			chk("cfg_one", d, {24'h0, c1});
			axi_rd(ACMS_OFF_CFG_TWO, d, r);
			chk("cfg_two", d, {28'h0, c2[3:0]});
			#1;
			chk("low_power", low_power_select, c1[7]);
			chk("resolution", resolution_bits, exp_res(c1[3:2], dif));
			chk("twos", twos_complement, dif);
			chk("sample", sample_cycles, exp_smp(c1[4], c2[1:0]));
			chk("conv", conversion_cycles, 6'(exp_smp(c1[4], c2[1:0])
				+ exp_res(c1[3:2], dif) + 4 * c2[2] + 2 * dif));
			raw = 16'($urandom);
			@(posedge clk_sys);
			raw_result <= raw;
			raw_result_valid <= 1'b1;
			@(posedge clk_sys);
			raw_result_valid <= 1'b0;
			#1;
			chk("result", result_data, exp_fmt(raw, exp_res(c1[3:2], dif), dif));
			chk("result valid", result_valid, 1'b1);
		end
		axi_wr(ACMS_OFF_CFG_TWO, 32'h0, 4'hF, r);
		// Bus and halved bus sources at every divider
		for (int s = 0; s < 2; s++)
			for (int v = 0; v < 4; v++)
			begin
				axi_wr(ACMS_OFF_CFG_ONE, 32'(v << 5 | s), 4'hF, r);
				gap(g);
				chk("tick gap", g, (s + 1) << v);
			end
		// Alternate clock of 7.5 system cycles
		axi_wr(ACMS_OFF_CFG_ONE, 32'h02, 4'hF, r);
		gap(g);
		chk("alt gap", 32'(g == 7 || g == 8), 1);
		// Converting from the bus clock leaves the async clock off
		conv_active <= 1'b1;
		axi_wr(ACMS_OFF_CFG_ONE, 32'h00, 4'hF, r);
		repeat (12) @(posedge clk_sys);
		chk("async off", async_clock_ready, 1'b0);
		conv_active <= 1'b0;
		axi_wr(ACMS_OFF_CFG_ONE, 32'h03, 4'hF, r);
		req("start pending", 1'b0);
		@(posedge clk_sys);
		conv_active <= 1'b1;
		n = 0;
		repeat (20)
		begin
			@(posedge clk_sys);
			n += int'(conv_start === 1'b1);
		end
		chk("late start", n, 1);
		chk("async on", async_clock_ready, 1'b1);
		conv_active <= 1'b0;
		repeat (10) @(posedge clk_sys);
		chk("async stopped", async_clock_ready, 1'b0);
		// Enable keeps the clock running while idle on another source
		axi_wr(ACMS_OFF_CFG_ONE, 32'h00, 4'hF, r);
		axi_wr(ACMS_OFF_CFG_TWO, 32'h08, 4'hF, r);
		repeat (20) @(posedge clk_sys);
		n = 0;
		repeat (16)
		begin
			@(posedge clk_sys);
			n += int'(internal_async_clock === 1'b1);
		end
		chk("async runs", 32'(n > 0 && n < 16), 1);
		axi_wr(ACMS_OFF_CFG_ONE, 32'h03, 4'hF, r);
		req("start at once", 1'b1);
		// No byte strobe stores nothing; unmapped place refused
		axi_wr(ACMS_OFF_CFG_ONE, 32'hFF, 4'h0, r);
		axi_rd(ACMS_OFF_CFG_ONE, d, r);
		chk("strobe off", d, 32'h03);
		axi_wr(8'h08, 32'h01, 4'hF, r);
		chk("unmapped wr", r, ACMS_RESP_SLVERR);
		axi_rd(8'h08, d, r);
		chk("unmapped rd resp", {30'h0, r}, {30'h0, ACMS_RESP_SLVERR});
		chk("unmapped rd data", d, 32'h0);
		// Second reset mid-run
		rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		axi_rd(ACMS_OFF_CFG_TWO, d, r);
		chk("cfg_two reset", d, 32'(ACMS_CFG_TWO_RST));
		end_sim();
	end
endmodule : tb
